// *** verilog/dsos_top.sv ***
// Drive status output selector with classic Wishbone register slave
// Behaviour
// RULE1: Four outputs, two digital two relay, own 5-bit selector, defaults 1,8,9,17.
// RULE2: Code 0 active while drive on and forward or reverse command present.
// RULE3: Code 1 active after soft start, drive enabled, no fault.
// RULE4: Code 2 ready and producing PWM (V/Hz) or flux present (vector).
// RULE5: Code 3 stop command present and motor stopped or coasting.
// RULE6: Code 4 active during jog mode.
// RULE7: Codes 5, 6, 7 accelerating, constant speed, decelerating.
// RULE8: Code 8 motor speed magnitude below zero-speed threshold.
// RULE9: Code 9 speed within band around speed reference.
// RULE10: Code 10 speed at or above speed-reached threshold.
// RULE11: Code 11 current above high threshold; code 12 below low threshold.
// RULE12: Code 13 remaining overload capacity below 100 percent.
// RULE13: Code 14 active under local keypad control.
// RULE14: Code 15 follows dynamic brake transistor.
// RULE15: Code 16 current foldback, only in V/Hz mode.
// RULE16: Code 17 tripping fault; code 18 non-tripping alarm.
// RULE17: Codes 19, 20 run commands; 21, 22 actual motor direction.
// RULE18: Code 23 absolute process error above process error limit.
// RULE19: Codes 24, 27, 28 driven by network, sequencer, clock module.
// RULE20: Code 25 at position and near zero speed; code 26 otherwise.
// RULE21: Code 29 bus up and no fault.
// RULE22: Code 30 trickle current heating active.
// RULE23: Code 31 contactor sequenced with delays around power stage.
// RULE24: Every output re-evaluated each cycle from its selected condition.
`include "dsos_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module dsos_top #(
    parameter int DW        = 16,
    parameter int CLOSE_CYC = `DSOS_CLOSE_MS * (`DSOS_CLK_HZ / 1000),
    parameter int OPEN_CYC  = `DSOS_OPEN_MS * (`DSOS_CLK_HZ / 1000)
) (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Wishbone slave
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [`DSOS_ADR_W-1:0] adr_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [31:0]           dat_i,
    output logic      [31:0]           dat_o,
    output logic                       ack_o,
    // Drive state flags
    input  wire logic                  drive_on_i,
    input  wire logic                  fwd_cmd_i,
    input  wire logic                  rev_cmd_i,
    input  wire logic                  soft_start_done_i,
    input  wire logic                  enabled_i,
    input  wire logic                  fault_i,
    input  wire logic                  alarm_i,
    input  wire logic                  vector_mode_i,
    input  wire logic                  pwm_active_i,
    input  wire logic                  flux_present_i,
    input  wire logic                  stop_cmd_i,
    input  wire logic                  motor_stopped_i,
    input  wire logic                  coasting_i,
    input  wire logic                  jog_i,
    input  wire logic                  accel_i,
    input  wire logic                  const_spd_i,
    input  wire logic                  decel_i,
    input  wire logic                  keypad_i,
    input  wire logic                  dyn_brake_i,
    input  wire logic                  foldback_i,
    input  wire logic                  bus_up_i,
    input  wire logic                  heater_i,
    input  wire logic                  run_req_i,
    // Drive quantities
    input  wire logic signed [DW-1:0]  motor_speed_i,
    input  wire logic signed [DW-1:0]  speed_ref_i,
    input  wire logic        [DW-1:0]  motor_current_i,
    input  wire logic        [DW-1:0]  overload_left_i,
    input  wire logic signed [DW-1:0]  process_error_i,
    input  wire logic signed [DW-1:0]  position_error_i,
    // External output sources
    input  wire logic [3:0]            plc_i,
    input  wire logic [3:0]            rtc_i,
    // Status outputs
    output logic                       dig_out1_o,
    output logic                       dig_out2_o,
    output logic                       relay_out1_o,
    output logic                       relay_out2_o,
    output logic                       pwm_enable_o
);

    function automatic logic [DW-1:0] mag(input logic signed [DW-1:0] v);
        mag = v[DW-1] ? DW'(-v) : DW'(v);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = be[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    // Register state
    logic [`DSOS_SEL_W-1:0] sel_reg [4];
    logic [`DSOS_SEL_W-1:0] sel_next [4];
    logic [DW-1:0]          zero_speed_threshold_reg;
    logic [DW-1:0]          speed_window_band_reg;
    logic [DW-1:0]          speed_reached_threshold_reg;
    logic [DW-1:0]          high_current_threshold_reg;
    logic [DW-1:0]          low_current_threshold_reg;
    logic [DW-1:0]          position_tolerance_reg;
    logic [DW-1:0]          process_error_limit_reg;
    logic [3:0]             net_reg;
    logic [3:0]             out_reg;
    logic                   ack_reg;
    logic [31:0]            dat_reg;
    logic                   contactor_reg;
    logic                   pwm_en_reg;
    logic [31:0]            cnt_reg;
    dsos_pkg::dsos_cont_e   ct_reg;
    dsos_pkg::dsos_cont_e   ct_next;

    // Bus decode
    wire        req    = cyc_i && stb_i && !ack_reg;
    wire        wr     = cyc_i && stb_i && we_i && ack_reg;
    wire        w_sel  = wr && (adr_i == `DSOS_OFF_SEL);
    wire        w_zero = wr && (adr_i == `DSOS_OFF_ZERO_SPD);
    wire        w_band = wr && (adr_i == `DSOS_OFF_SPD_BAND);
    wire        w_rch  = wr && (adr_i == `DSOS_OFF_SPD_REACH);
    wire        w_hi   = wr && (adr_i == `DSOS_OFF_HI_CUR);
    wire        w_lo   = wr && (adr_i == `DSOS_OFF_LO_CUR);
    wire        w_pos  = wr && (adr_i == `DSOS_OFF_POS_TOL);
    wire        w_perr = wr && (adr_i == `DSOS_OFF_PERR_LIM);
    wire        w_net  = wr && (adr_i == `DSOS_OFF_NET);

    wire [31:0] sel_word = {3'h0, sel_reg[3], 3'h0, sel_reg[2], 3'h0, sel_reg[1], 3'h0, sel_reg[0]};
    wire [31:0] sel_wm   = merge(sel_word, dat_i, sel_i);
    wire [31:0] stat_word = {25'h0, pwm_en_reg, 2'(ct_reg), out_reg};

    // Condition vector
    wire [DW-1:0] spd_mag  = mag(motor_speed_i);
    wire [DW-1:0] spd_diff = mag(DW'(motor_speed_i - speed_ref_i));
    wire          drv_ready = soft_start_done_i && enabled_i && !fault_i;
    wire          at_pos   = (mag(position_error_i) <= position_tolerance_reg)
                          && (spd_mag <= zero_speed_threshold_reg);
    logic [31:0]  cond_vec;
    assign cond_vec[0]  = drive_on_i && (fwd_cmd_i || rev_cmd_i); // RULE2
    assign cond_vec[1]  = drv_ready; // RULE3
    assign cond_vec[2]  = drv_ready && (vector_mode_i ? flux_present_i : pwm_active_i); // RULE4
    assign cond_vec[3]  = stop_cmd_i && (motor_stopped_i || coasting_i); // RULE5
    assign cond_vec[4]  = jog_i; // RULE6
    assign cond_vec[5]  = accel_i; // RULE7
    assign cond_vec[6]  = const_spd_i; // RULE7
    assign cond_vec[7]  = decel_i; // RULE7
    assign cond_vec[8]  = spd_mag < zero_speed_threshold_reg; // RULE8
    assign cond_vec[9]  = spd_diff < speed_window_band_reg; // RULE9
    assign cond_vec[10] = spd_mag >= speed_reached_threshold_reg; // RULE10
    assign cond_vec[11] = motor_current_i > high_current_threshold_reg; // RULE11
    assign cond_vec[12] = motor_current_i < low_current_threshold_reg; // RULE11
    assign cond_vec[13] = overload_left_i < DW'(`DSOS_OVL_FULL); // RULE12
    assign cond_vec[14] = keypad_i; // RULE13
    assign cond_vec[15] = dyn_brake_i; // RULE14
    assign cond_vec[16] = foldback_i && !vector_mode_i; // RULE15
    assign cond_vec[17] = fault_i; // RULE16
    assign cond_vec[18] = alarm_i; // RULE16
    assign cond_vec[19] = fwd_cmd_i; // RULE17
    assign cond_vec[20] = rev_cmd_i; // RULE17
    assign cond_vec[21] = !motor_speed_i[DW-1] && (motor_speed_i != '0); // RULE17
    assign cond_vec[22] = motor_speed_i[DW-1]; // RULE17
    assign cond_vec[23] = mag(process_error_i) > process_error_limit_reg; // RULE18
    assign cond_vec[24] = 1'b0;
    assign cond_vec[25] = at_pos; // RULE20
    assign cond_vec[26] = !at_pos; // RULE20
    assign cond_vec[27] = 1'b0;
    assign cond_vec[28] = 1'b0;
    assign cond_vec[29] = bus_up_i && !fault_i; // RULE21
    assign cond_vec[30] = heater_i; // RULE22
    assign cond_vec[31] = contactor_reg; // RULE23

    // Per-output pick, external sources are per output
    logic [3:0] pick;
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            unique case (sel_reg[k])
                5'h18:   pick[k] = net_reg[k]; // RULE19
                5'h1B:   pick[k] = plc_i[k]; // RULE19
                5'h1C:   pick[k] = rtc_i[k]; // RULE19
                default: pick[k] = cond_vec[sel_reg[k]];
            endcase
        end
    end

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            sel_next[k] = w_sel ? sel_wm[k*8 +: `DSOS_SEL_W] : sel_reg[k];
        end
    end

    // Read mux
    logic [31:0] rd_data;
    always_comb begin
        unique case (adr_i)
            `DSOS_OFF_SEL:       rd_data = sel_word;
            `DSOS_OFF_ZERO_SPD:  rd_data = 32'(zero_speed_threshold_reg);
            `DSOS_OFF_SPD_BAND:  rd_data = 32'(speed_window_band_reg);
            `DSOS_OFF_SPD_REACH: rd_data = 32'(speed_reached_threshold_reg);
            `DSOS_OFF_HI_CUR:    rd_data = 32'(high_current_threshold_reg);
            `DSOS_OFF_LO_CUR:    rd_data = 32'(low_current_threshold_reg);
            `DSOS_OFF_POS_TOL:   rd_data = 32'(position_tolerance_reg);
            `DSOS_OFF_PERR_LIM:  rd_data = 32'(process_error_limit_reg);
            `DSOS_OFF_NET:       rd_data = {28'h0, net_reg};
            `DSOS_OFF_STATUS:    rd_data = stat_word;
            `DSOS_OFF_COND:      rd_data = cond_vec;
            default:             rd_data = 32'h0;
        endcase
    end

    // Contactor sequencer
    wire cnt_done = (cnt_reg == 32'h0);
    always_comb begin
        ct_next = ct_reg;
        unique case (ct_reg)
            dsos_pkg::CT_OPEN:    if (run_req_i && !fault_i) ct_next = dsos_pkg::CT_CLOSING;
            dsos_pkg::CT_CLOSING: if (!run_req_i || fault_i) ct_next = dsos_pkg::CT_OPENING;
                                  else if (cnt_done) ct_next = dsos_pkg::CT_CLOSED;
            dsos_pkg::CT_CLOSED:  if (!run_req_i || fault_i) ct_next = dsos_pkg::CT_OPENING;
            dsos_pkg::CT_OPENING: if (cnt_done) ct_next = dsos_pkg::CT_OPEN;
        endcase
    end
    wire        ct_chg   = (ct_next != ct_reg);
    wire [31:0] cnt_load = (ct_next == dsos_pkg::CT_CLOSING) ? 32'(CLOSE_CYC - 1) : 32'(OPEN_CYC - 1);
    wire [31:0] cnt_next = ct_chg ? cnt_load : (cnt_done ? cnt_reg : cnt_reg - 32'h1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ct_reg        <= dsos_pkg::CT_OPEN;
            cnt_reg       <= 32'h0;
            contactor_reg <= 1'b0;
            pwm_en_reg    <= 1'b0;
        end else begin
            ct_reg        <= ct_next; // RULE23
            cnt_reg       <= cnt_next;
            contactor_reg <= (ct_next != dsos_pkg::CT_OPEN); // RULE23
            pwm_en_reg    <= (ct_next == dsos_pkg::CT_CLOSED); // RULE23
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_reg[0] <= `DSOS_SEL0_RST; // RULE1
            sel_reg[1] <= `DSOS_SEL1_RST; // RULE1
            sel_reg[2] <= `DSOS_SEL2_RST; // RULE1
            sel_reg[3] <= `DSOS_SEL3_RST; // RULE1
            out_reg    <= 4'h0;
        end else begin
            sel_reg    <= sel_next;
            out_reg    <= pick; // RULE24
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            zero_speed_threshold_reg    <= `DSOS_ZERO_SPD_RST;
            speed_window_band_reg       <= `DSOS_SPD_BAND_RST;
            speed_reached_threshold_reg <= `DSOS_SPD_REACH_RST;
            high_current_threshold_reg  <= `DSOS_HI_CUR_RST;
            low_current_threshold_reg   <= `DSOS_LO_CUR_RST;
            position_tolerance_reg      <= `DSOS_POS_TOL_RST;
            process_error_limit_reg     <= `DSOS_PERR_LIM_RST;
            net_reg                     <= 4'h0;
        end else begin
            if (w_zero) zero_speed_threshold_reg    <= DW'(merge(32'(zero_speed_threshold_reg), dat_i, sel_i));
            if (w_band) speed_window_band_reg       <= DW'(merge(32'(speed_window_band_reg), dat_i, sel_i));
            if (w_rch)  speed_reached_threshold_reg <= DW'(merge(32'(speed_reached_threshold_reg), dat_i, sel_i));
            if (w_hi)   high_current_threshold_reg  <= DW'(merge(32'(high_current_threshold_reg), dat_i, sel_i));
            if (w_lo)   low_current_threshold_reg   <= DW'(merge(32'(low_current_threshold_reg), dat_i, sel_i));
            if (w_pos)  position_tolerance_reg      <= DW'(merge(32'(position_tolerance_reg), dat_i, sel_i));
            if (w_perr) process_error_limit_reg     <= DW'(merge(32'(process_error_limit_reg), dat_i, sel_i));
            if (w_net && sel_i[0]) net_reg          <= dat_i[3:0]; // RULE19
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else begin
            ack_reg <= req;
            dat_reg <= (req && !we_i) ? rd_data : 32'h0;
        end
    end

    assign ack_o        = ack_reg;
    assign dat_o        = dat_reg;
    assign dig_out1_o   = out_reg[0];
    assign dig_out2_o   = out_reg[1];
    assign relay_out1_o = out_reg[2];
    assign relay_out2_o = out_reg[3];
    assign pwm_enable_o = pwm_en_reg;

    default clocking dsos_cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_sel_defaults: // RULE1
    assert property ($past(rst_i) |-> sel_word == 32'h11090801)
        else $error("selector defaults wrong after reset");
    a_out_track: // RULE24
    assert property (!$past(rst_i) |-> out_reg == $past(pick))
        else $error("outputs do not follow selected condition");
    a_run_out: // RULE2
    assert property ((sel_reg[0] == 5'h00 && drive_on_i && fwd_cmd_i) |=> dig_out1_o)
        else $error("drive run not shown");
    a_ready_out: // RULE3
    assert property ((sel_reg[0] == 5'h01 && soft_start_done_i && enabled_i && fault_i) |=> !dig_out1_o)
        else $error("ready shown during fault");
    a_zero_out: // RULE8
    assert property ((sel_reg[1] == 5'h08 && spd_mag < zero_speed_threshold_reg) |=> dig_out2_o)
        else $error("zero speed not shown");
    a_fault_out: // RULE16
    assert property ((sel_reg[3] == 5'h11) |=> relay_out2_o == $past(fault_i))
        else $error("fault relay mismatch");
    a_net_out: // RULE19
    assert property ((sel_reg[0] == 5'h18) |=> dig_out1_o == $past(net_reg[0]))
        else $error("network output mismatch");
    a_pos_pair: // RULE20
    assert property ((sel_reg[0] == 5'h1A && position_error_i == '0 && spd_mag <= zero_speed_threshold_reg)
                     |=> !dig_out1_o)
        else $error("in motion shown at rest");
    a_cont_close: // RULE23
    assert property ($rose(pwm_en_reg) |-> contactor_reg && $past(contactor_reg, 2))
        else $error("power stage enabled before contactor settled");
    a_cont_open: // RULE23
    assert property ($fell(contactor_reg) |-> !pwm_en_reg && !$past(pwm_en_reg, 2))
        else $error("contactor opened under power");
    a_bus_ack:
    assert property (req |=> ack_reg ##1 !ack_reg)
        else $error("bus ack not one cycle");
    a_stop_out: // RULE5
    assert property ((sel_reg[0] == 5'h03 && stop_cmd_i && coasting_i) |=> dig_out1_o)
        else $error("stopped state not shown");
    a_vec_flux: // RULE4
    assert property ((sel_reg[0] == 5'h02 && vector_mode_i && !flux_present_i) |=> !dig_out1_o)
        else $error("drive on shown without flux");
    a_hi_cur: // RULE11
    assert property ((sel_reg[0] == 5'h0B && motor_current_i <= high_current_threshold_reg) |=> !dig_out1_o)
        else $error("overcurrent shown below threshold");
    a_ovl_full: // RULE12
    assert property ((sel_reg[0] == 5'h0D && overload_left_i >= DW'(`DSOS_OVL_FULL)) |=> !dig_out1_o)
        else $error("overload shown at full capacity");
    a_fold_vhz: // RULE15
    assert property ((sel_reg[0] == 5'h10 && vector_mode_i) |=> !dig_out1_o)
        else $error("foldback shown in vector mode");
    a_pwr_up: // RULE21
    assert property ((sel_reg[0] == 5'h1D && !bus_up_i) |=> !dig_out1_o)
        else $error("powered up shown with bus down");
    a_cont_out: // RULE23
    assert property ((sel_reg[3] == 5'h1F) |=> relay_out2_o == $past(contactor_reg))
        else $error("contactor relay mismatch");
    a_pwm_gate: // RULE23
    assert property (pwm_en_reg |-> contactor_reg)
        else $error("power stage enabled with contactor open");
    a_sel_hold: // RULE24
    assert property (!w_sel |=> $stable(sel_word))
        else $error("selectors changed without write");

    c_cont_closed: cover property ($rose(pwm_en_reg));
    c_sel_write:   cover property (w_sel ##1 $changed(sel_word));
    c_fault_relay: cover property (sel_reg[3] == 5'h11 && fault_i ##1 relay_out2_o);
    c_net_write:   cover property (w_net ##1 $changed(net_reg));
    c_at_pos:      cover property (sel_reg[0] == 5'h19 && dig_out1_o);

endmodule

`default_nettype wire

// *** verilog/dsos_consts.svh ***
// Constants for the drive status output selector
`ifndef DSOS_CONSTS_SVH
`define DSOS_CONSTS_SVH

`define DSOS_CLK_HZ        25000000
`define DSOS_ADR_W         8

`define DSOS_OFF_SEL       8'h00
`define DSOS_OFF_ZERO_SPD  8'h04
`define DSOS_OFF_SPD_BAND  8'h08
`define DSOS_OFF_SPD_REACH 8'h0C
`define DSOS_OFF_HI_CUR    8'h10
`define DSOS_OFF_LO_CUR    8'h14
`define DSOS_OFF_POS_TOL   8'h18
`define DSOS_OFF_PERR_LIM  8'h1C
`define DSOS_OFF_NET       8'h20
`define DSOS_OFF_STATUS    8'h24
`define DSOS_OFF_COND      8'h28

`define DSOS_SEL_W         5
`define DSOS_SEL0_LSB      0
`define DSOS_SEL1_LSB      8
`define DSOS_SEL2_LSB      16
`define DSOS_SEL3_LSB      24

`define DSOS_SEL0_RST      5'h01
`define DSOS_SEL1_RST      5'h08
`define DSOS_SEL2_RST      5'h09
`define DSOS_SEL3_RST      5'h11

`define DSOS_ZERO_SPD_RST  16'h00B4
`define DSOS_SPD_BAND_RST  16'h003C
`define DSOS_SPD_REACH_RST 16'h0708
`define DSOS_HI_CUR_RST    16'h05DC
`define DSOS_LO_CUR_RST    16'h01F4
`define DSOS_POS_TOL_RST   16'h0000
`define DSOS_PERR_LIM_RST  16'h0000
`define DSOS_OVL_FULL      16'h0064

`define DSOS_CLOSE_MS      20
`define DSOS_OPEN_MS       20

`endif

// *** verilog/dsos_pkg.sv ***
// Types for the drive status output selector
package dsos_pkg;
    typedef enum logic [1:0] {
        CT_OPEN,
        CT_CLOSING,
        CT_CLOSED,
        CT_OPENING
    } dsos_cont_e;
endpackage

// *** verif/dsos_contactor_model.sv ***
// Contactor and power stage load model on the far side of the status outputs
`timescale 1ns/100ps
`default_nettype none

module dsos_contactor_model (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Contactor coil and power stage enable
    input  wire logic coil_i,
    input  wire logic pwm_enable_i,
    // Sequence fault seen by the load
    output logic      bad_seq_o
);
    logic closed_reg;

    // Contacts follow the coil one cycle late
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            closed_reg <= 1'b0;
            bad_seq_o  <= 1'b0;
        end else begin
            closed_reg <= coil_i;
            if (pwm_enable_i && !closed_reg) begin
                bad_seq_o <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// *** verif/tb_drive_status_output_selector.sv ***
// Testbench for the drive status output selector
`include "dsos_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_drive_status_output_selector;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, bad_seq;
    logic [7:0] adr_i;
    logic [3:0] sel_i, plc_i, rtc_i;
    logic [31:0] dat_i, dat_o, rd;
    logic drive_on_i, fwd_cmd_i, rev_cmd_i, soft_start_done_i, enabled_i, fault_i, alarm_i;
    logic vector_mode_i, pwm_active_i, flux_present_i, stop_cmd_i, motor_stopped_i, coasting_i;
    logic jog_i, accel_i, const_spd_i, decel_i, keypad_i, dyn_brake_i, foldback_i, bus_up_i;
    logic heater_i, run_req_i, dig_out1_o, dig_out2_o, relay_out1_o, relay_out2_o, pwm_enable_o;
    logic signed [15:0] motor_speed_i, speed_ref_i, process_error_i, position_error_i;
    logic [15:0] motor_current_i, overload_left_i;
    int num_errors, samples_checked, cycles, n;
    logic [15:0] thr_rst [0:6] = '{16'h00B4, 16'h003C, 16'h0708, 16'h05DC, 16'h01F4, 16'h0000, 16'h0000};

    dsos_top #(.DW(16), .CLOSE_CYC(8), .OPEN_CYC(6)) DUT (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .drive_on_i, .fwd_cmd_i, .rev_cmd_i, .soft_start_done_i, .enabled_i, .fault_i, .alarm_i,
        .vector_mode_i, .pwm_active_i, .flux_present_i, .stop_cmd_i, .motor_stopped_i, .coasting_i,
        .jog_i, .accel_i, .const_spd_i, .decel_i, .keypad_i, .dyn_brake_i, .foldback_i, .bus_up_i,
        .heater_i, .run_req_i, .motor_speed_i, .speed_ref_i, .motor_current_i, .overload_left_i,
        .process_error_i, .position_error_i, .plc_i, .rtc_i, .dig_out1_o, .dig_out2_o,
        .relay_out1_o, .relay_out2_o, .pwm_enable_o);

    dsos_contactor_model partner (.clk_i(clk_i), .rst_i(rst_i), .coil_i(relay_out2_o),
        .pwm_enable_i(pwm_enable_o), .bad_seq_o(bad_seq));

    always #20 clk_i = ~clk_i;

    task automatic final_report();
        if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Classic single cycle, held until ack is sampled
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    endtask

    task automatic baseline();
        @(posedge clk_i);
        {drive_on_i, fwd_cmd_i, rev_cmd_i, soft_start_done_i, enabled_i, fault_i, alarm_i} <= '0;
        {vector_mode_i, pwm_active_i, flux_present_i, stop_cmd_i, motor_stopped_i, coasting_i} <= '0;
        {jog_i, accel_i, const_spd_i, decel_i, keypad_i, dyn_brake_i, foldback_i, bus_up_i} <= '0;
        {heater_i, run_req_i, plc_i, rtc_i} <= '0;
        motor_speed_i <= 16'sh03E8; speed_ref_i <= 16'sh0000; motor_current_i <= 16'h03E8;
        overload_left_i <= 16'h0064; process_error_i <= '0; position_error_i <= '0;
    endtask

    task automatic set_cond(input int c, input logic on);
        @(posedge clk_i);
        case (c)
            0: begin drive_on_i <= on; fwd_cmd_i <= on; end
            1: begin soft_start_done_i <= on; enabled_i <= on; end
            2: begin soft_start_done_i <= 1'b1; enabled_i <= 1'b1; pwm_active_i <= 1'b1; vector_mode_i <= !on; end
            3: begin stop_cmd_i <= on; coasting_i <= on; end
            4: jog_i <= on;
            5: accel_i <= on;
            6: const_spd_i <= on;
            7: decel_i <= on;
            8: motor_speed_i <= on ? 16'sh00B3 : 16'sh00B4;
            9: speed_ref_i <= on ? 16'sh03C5 : 16'sh03AC;
            10: motor_speed_i <= on ? 16'sh0708 : 16'sh0707;
            11: motor_current_i <= on ? 16'h05DD : 16'h05DC;
            12: motor_current_i <= on ? 16'h01F3 : 16'h01F4;
            13: overload_left_i <= on ? 16'h0063 : 16'h0064;
            14: keypad_i <= on;
            15: dyn_brake_i <= on;
            16: begin foldback_i <= 1'b1; vector_mode_i <= !on; end
            17: fault_i <= on;
            18: alarm_i <= on;
            19: fwd_cmd_i <= on;
            20: rev_cmd_i <= on;
            21: motor_speed_i <= on ? 16'sh03E8 : -16'sh03E8;
            22: motor_speed_i <= on ? -16'sh03E8 : 16'sh03E8;
            23: process_error_i <= on ? -16'sh0005 : 16'sh0000;
            24: wb_cycle(1'b1, `DSOS_OFF_NET, {31'h0, on});
            25: motor_speed_i <= on ? 16'sh00B4 : 16'sh00B5;
            26: motor_speed_i <= on ? 16'sh00B5 : 16'sh00B4;
            27: plc_i <= {3'h0, on};
            28: rtc_i <= {3'h0, on};
            29: bus_up_i <= on;
            30: heater_i <= on;
            default: ;
        endcase
    endtask

    initial begin
        clk_i = 1'b0; rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0;
        adr_i = '0; sel_i = '0; dat_i = '0; num_errors = 0; samples_checked = 0; cycles = 0;
        baseline();
        @(posedge clk_i);
        rst_i <= 1'b0;
        wb_cycle(1'b0, `DSOS_OFF_SEL, '0);
        check(rd, 32'h11090801);
        for (int i = 0; i < 7; i++) begin
            wb_cycle(1'b0, 8'(4 * i + 4), '0);
            check(rd, {16'h0000, thr_rst[i]});
        end
        wb_cycle(1'b0, 8'h3C, '0);
        check(rd, 32'h0);
        @(posedge clk_i);
        fault_i <= 1'b1; motor_speed_i <= 16'sh0064; soft_start_done_i <= 1'b1; enabled_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        check({28'h0, dig_out1_o, dig_out2_o, relay_out1_o, relay_out2_o}, 32'h5);
        for (int c = 0; c < 31; c++) begin
            wb_cycle(1'b1, `DSOS_OFF_SEL, {11'h0, 5'h09, 3'h0, 5'h08, 3'h0, 5'(c)});
            for (int k = 1; k >= 0; k--) begin
                baseline();
                set_cond(c, k[0]);
                repeat (3) @(posedge clk_i);
                check({31'h0, dig_out1_o}, {31'h0, k[0]});
                check({31'h0, relay_out1_o}, {31'h0, c == 9 && k[0]});
            end
        end
        wb_cycle(1'b1, `DSOS_OFF_SEL, 32'h1F090801);
        baseline();
        @(posedge clk_i);
        fault_i <= 1'b1; run_req_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        check({31'h0, relay_out2_o}, 32'h0);
        fault_i <= 1'b0;
        n = 0;
        while (relay_out2_o !== 1'b1 && n < 40) begin @(posedge clk_i); n++; end
        check(32'(n < 5), 32'h1);
        n = 0;
        while (pwm_enable_o !== 1'b1 && n < 40) begin @(posedge clk_i); n++; end
        check(32'(n >= 6 && n <= 10), 32'h1);
        run_req_i <= 1'b0;
        n = 0;
        while (pwm_enable_o !== 1'b0 && n < 40) begin @(posedge clk_i); n++; end
        check(32'(n < 4), 32'h1);
        n = 0;
        while (relay_out2_o !== 1'b0 && n < 40) begin @(posedge clk_i); n++; end
        check(32'(n >= 4 && n <= 9), 32'h1);
        check({31'h0, bad_seq}, 32'h0);
        final_report();
    end
endmodule

`default_nettype wire
